// ==== shared/bba_pkg.sv ====
// Purpose: Shared constants and types for the byte and bit execution datapath.
// Assumes: One 20 MHz core clock; an instruction cycle is four clock periods.
// Notes: Operation codes are internal to this block and not an instruction encoding.
package bba_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int PHASES_PER_CYCLE = 4;
  localparam int NIBBLE_CARRY_BIT = 4;
  localparam int CLK_HZ = 20000000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_FIRST = 2'h0;
  localparam logic [1:0] PHASE_STEP = 2'h1;

  typedef enum logic [3:0] {
    BBA_OP_NOP = 4'h0,
    BBA_OP_ADD_LIT = 4'h1,
    BBA_OP_AND_LIT = 4'h2,
    BBA_OP_ADD_REG = 4'h3,
    BBA_OP_AND_REG = 4'h4,
    BBA_OP_BIT_CLR = 4'h5,
    BBA_OP_BIT_SET = 4'h6,
    BBA_OP_BIT_SKIP1 = 4'h7,
    BBA_OP_REG_CLR = 4'h8
  } bba_op_t;
endpackage : bba_pkg

// ==== rtl/bba_alu.sv ====
// Purpose: Combinational arithmetic and logic core of the execution datapath.
// Assumes: Operands are stable for the cycle in which the result is used.
// Notes: Carries are produced for every add; the caller decides which flags to store.
module bba_alu (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic do_and,
  output logic [7:0] result,
  output logic carry,
  output logic nibble_carry,
  output logic is_zero
);
  logic [8:0] sum;
  logic [4:0] low_sum;

  // Both carries come from widened sums so no bit is lost silently.
  always_comb begin
    sum = {1'b0, a} + {1'b0, b};
    low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    result = do_and ? (a & b) : sum[7:0];
    carry = do_and ? 1'b0 : sum[8];
    nibble_carry = do_and ? 1'b0 : low_sum[bba_pkg::NIBBLE_CARRY_BIT];
    is_zero = (result == bba_pkg::ZERO_BYTE);
  end
endmodule : bba_alu

// ==== rtl/bba_core.sv ====
// Purpose: Executes a subset of byte and bit operations on an accumulator and register file.
// Assumes: Opcode, operands and issue are synchronous to sys_clk and held while busy is low.
// Notes: Each instruction takes four clocks; a taken skip adds a four-clock no-operation.
// Overview of operation
// - Literal add: accumulator plus literal into accumulator, all three flags updated.
// - Literal AND: accumulator AND literal into accumulator, only null flag updated.
// - Register add: accumulator plus selected register, all three flags updated.
// - Register AND: accumulator AND selected register, only null flag updated.
// - Target select (register add and AND only): 0 writes accumulator, 1 writes the selected register back.
// - Bit clear: chosen bit of register forced zero, other bits and flags kept.
// - Bit set: chosen bit of register forced one, other bits and flags kept.
// - Bit test: if bit is one, skip next instruction, two cycles, no flags.
// - Register clear: selected register becomes zero and null flag is set.
// - Cycle is four clocks; skips add a second no-operation cycle.
module bba_core #(
  parameter int DEPTH = 128
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic issue,
  input wire logic [3:0] opcode,
  input wire logic [7:0] literal_operand,
  input wire logic [6:0] register_operand,
  input wire logic [2:0] position_index,
  input wire logic result_target_select,
  output logic busy,
  output logic done,
  output logic skip_taken,
  output logic [7:0] accumulator,
  output logic byte_overflow_flag,
  output logic nibble_overflow_flag,
  output logic null_result_flag
);
  // Idle waits for issue, exec runs one instruction cycle, skip runs the no-operation cycle.
  typedef enum logic [1:0] {BBA_IDLE, BBA_EXEC, BBA_SKIP} bba_state_t;

  // Captured operands live in the state, so the inputs may change once the take edge passed.
  typedef struct packed {
    bba_state_t st;
    logic [1:0] phase;
    bba_pkg::bba_op_t op;
    logic [7:0] lit;
    logic [6:0] addr;
    logic [2:0] pos;
    logic tgt;
    logic busy;
    logic done;
    logic skip;
    logic [7:0] acc;
    logic cflag;
    logic dcflag;
    logic zflag;
  } bba_core_state_t;

  bba_core_state_t s_q, s_d;
  // Register file storage and the datapath wires around it.
  logic [7:0] file_mem [DEPTH];
  logic file_we;
  logic [7:0] file_wdata;
  logic [7:0] file_rdata;
  logic [7:0] alu_b;
  logic [7:0] alu_res;
  logic alu_c, alu_dc, alu_z;

  // Refuse a file larger than the register operand can address, or an empty one.
  // The check runs at elaboration so a bad build never reaches simulation.
  if (DEPTH < 1 || DEPTH > (1 << bba_pkg::ADDR_W)) begin : g_depth_check
    $error("bba_core: DEPTH must be 1 to 128");
  end

  // Builds a one-hot mask for the chosen bit position.
  function automatic logic [7:0] bit_mask(input logic [2:0] pos);
    bit_mask = 8'h01 << pos;
  endfunction : bit_mask

  // True when an address falls inside the implemented part of the file.
  // A reduced DEPTH leaves upper addresses unimplemented rather than aliased.
  function automatic logic addr_in_range(input logic [6:0] addr);
    addr_in_range = (32'(addr) < DEPTH);
  endfunction : addr_in_range

  // Register reads are combinational; addresses beyond DEPTH read zero.
  assign file_rdata = addr_in_range(s_q.addr) ? file_mem[s_q.addr] : bba_pkg::ZERO_BYTE;
  // The second operand is the literal for literal ops and the file register otherwise.
  assign alu_b = (s_q.op == bba_pkg::BBA_OP_ADD_LIT || s_q.op == bba_pkg::BBA_OP_AND_LIT)
    ? s_q.lit : file_rdata;

  // One shared adder and AND serve the four add and AND operations; the commit logic picks the flags kept.
  bba_alu u_alu (
    .a(s_q.acc),
    .b(alu_b),
    .do_and(s_q.op == bba_pkg::BBA_OP_AND_LIT || s_q.op == bba_pkg::BBA_OP_AND_REG),
    .result(alu_res),
    .carry(alu_c),
    .nibble_carry(alu_dc),
    .is_zero(alu_z)
  );

  // Next-state logic; the result commits on the last phase of the instruction cycle.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    file_we = 1'b0;
    file_wdata = alu_res;
    case (s_q.st)
      BBA_IDLE: begin
        // The skip indication stands until the next instruction is accepted, so the fetch
        // side can drop its prefetched word at any time before it issues again.
        if (issue) begin
          s_d.skip = 1'b0;
          s_d.op = bba_pkg::bba_op_t'(opcode);
          s_d.lit = literal_operand;
          s_d.addr = register_operand;
          s_d.pos = position_index;
          s_d.tgt = result_target_select;
          s_d.phase = bba_pkg::PHASE_FIRST;
          s_d.busy = 1'b1;
          s_d.st = BBA_EXEC;
        end
      end
      BBA_EXEC: begin
        // The phase counter wraps through four clocks and lands back on the first phase.
        s_d.phase = s_q.phase + bba_pkg::PHASE_STEP;
        if (s_q.phase == bba_pkg::PHASE_LAST) begin
          s_d.st = BBA_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          case (s_q.op)
            // Literal ops ignore the target bit; the literal never names a register.
            bba_pkg::BBA_OP_ADD_LIT: begin
              s_d.acc = alu_res;
              s_d.cflag = alu_c;
              s_d.dcflag = alu_dc;
              s_d.zflag = alu_z;
            end
            bba_pkg::BBA_OP_AND_LIT: begin
              s_d.acc = alu_res;
              s_d.zflag = alu_z;
            end
            bba_pkg::BBA_OP_ADD_REG, bba_pkg::BBA_OP_AND_REG: begin
              if (s_q.tgt) begin
                file_we = 1'b1;
              end else begin
                s_d.acc = alu_res;
              end
              s_d.zflag = alu_z;
              if (s_q.op == bba_pkg::BBA_OP_ADD_REG) begin
                s_d.cflag = alu_c;
                s_d.dcflag = alu_dc;
              end
            end
            // Bit clear and set rewrite the whole byte; the other seven bits pass through unchanged.
            bba_pkg::BBA_OP_BIT_CLR: begin
              file_we = 1'b1;
              file_wdata = file_rdata & ~bit_mask(s_q.pos);
            end
            bba_pkg::BBA_OP_BIT_SET: begin
              file_we = 1'b1;
              file_wdata = file_rdata | bit_mask(s_q.pos);
            end
            bba_pkg::BBA_OP_BIT_SKIP1: begin
              // A taken skip keeps busy high for one more full no-operation cycle.
              // Flags are never touched here; only the control fields change.
              if ((file_rdata & bit_mask(s_q.pos)) != bba_pkg::ZERO_BYTE) begin
                s_d.st = BBA_SKIP;
                s_d.busy = 1'b1;
                s_d.done = 1'b0;
                s_d.skip = 1'b1;
              end
            end
            // Clear reports a zero result without going through the ALU.
            bba_pkg::BBA_OP_REG_CLR: begin
              file_we = 1'b1;
              file_wdata = bba_pkg::ZERO_BYTE;
              s_d.zflag = 1'b1;
            end
            default: begin
            end
          endcase
        end
      end
      BBA_SKIP: begin
        s_d.phase = s_q.phase + bba_pkg::PHASE_STEP;
        if (s_q.phase == bba_pkg::PHASE_LAST) begin
          s_d.st = BBA_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end
      // An illegal state returns to idle; busy keeps its value and is not cleared here.
      default: begin
        s_d.st = BBA_IDLE;
      end
    endcase
  end

  // Control state resets; the register file is data storage and has no reset.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.acc <= bba_pkg::ACC_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Register file write port, one write at the end of an instruction cycle.
  // Writes to unimplemented addresses are dropped, matching the zero read.
  always_ff @(posedge sys_clk) begin
    if (file_we && addr_in_range(s_q.addr)) begin
      file_mem[s_q.addr] <= file_wdata;
    end
  end

  // Outputs come straight from the state flops.
  assign busy = s_q.busy;
  assign done = s_q.done;
  assign skip_taken = s_q.skip;
  assign accumulator = s_q.acc;
  assign byte_overflow_flag = s_q.cflag;
  assign nibble_overflow_flag = s_q.dcflag;
  assign null_result_flag = s_q.zflag;
endmodule : bba_core

// ==== dv/bba_core_assertions.sv ====
// Purpose: Port checks for the byte and bit datapath.
// Assumes: Operation codes of the shared package.
// Notes: Operation and target are captured at the take edge.
module bba_core_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic issue,
  input wire logic [3:0] opcode,
  input wire logic result_target_select,
  input wire logic busy,
  input wire logic done,
  input wire logic skip_taken,
  input wire logic [7:0] accumulator,
  input wire logic byte_overflow_flag,
  input wire logic nibble_overflow_flag,
  input wire logic null_result_flag
);
  logic [4:0] cap_q;
  // Inputs may move while busy, so completion checks use the captured operation.
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) cap_q <= 5'h00;
    else if (issue && !busy) cap_q <= {opcode, result_target_select};
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Busy is seen on the four clocks after the take edge; the end shows on the fifth.
  sequence s_run;
    busy [*4] ##1 (done || skip_taken);
  endsequence
  // The no-operation cycle of a taken skip: three quiet clocks, then the closing pulse.
  sequence s_skip_tail;
    !done [*3] ##1 done;
  endsequence
  a_take_time: assert property (issue && !busy |=> s_run)
    else $error("instruction not ended in four clocks");
  a_skip_time: assert property ($rose(skip_taken) |=> s_skip_tail)
    else $error("skip not ended four clocks later");
  a_done_pulse: assert property (done |=> !done) else $error("done held");
  a_acc_hold: assert property (!done |-> $stable(accumulator))
    else $error("accumulator moved outside completion");
  a_null_acc: assert property (done && cap_q inside {5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
      5'h08} |-> null_result_flag == (accumulator == 8'h00)) else $error("null flag wrong");
  a_and_carry: assert property (done && cap_q[4:1] inside {4'h2, 4'h4} |->
      $stable({byte_overflow_flag, nibble_overflow_flag})) else $error("and moved carry");
  a_reg_target: assert property (done && cap_q inside {5'h07, 5'h09} |->
      $stable(accumulator)) else $error("register target wrote accumulator");
  a_clr_null: assert property (done && cap_q[4:1] == 4'h8 |-> null_result_flag)
    else $error("clear left null low");
endmodule : bba_core_chk
bind bba_core bba_core_chk u_chk (.sys_clk, .nrst, .issue, .opcode, .result_target_select,
  .busy, .done, .skip_taken, .accumulator, .byte_overflow_flag, .nibble_overflow_flag,
  .null_result_flag);

// ==== dv/test_byte_bit_alu_ops.sv ====
// Purpose: Directed bench for the byte and bit datapath.
// Assumes: Inputs move on the falling edge.
// Notes: Registers have no reset, so each one used is cleared first.
module test_byte_bit_alu_ops;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, nrst, issue, tgt, busy, done, skip, c, dc, z;
  logic [3:0] op;
  logic [7:0] lit, acc;
  logic [6:0] adr;
  logic [2:0] pos;
  int err_total, checks_done, lat;
  wire logic [10:0] st = {acc, c, dc, z};
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
  bba_core dut (.sys_clk, .nrst, .issue, .opcode(op), .literal_operand(lit),
    .register_operand(adr), .position_index(pos), .result_target_select(tgt), .busy,
    .done, .skip_taken(skip), .accumulator(acc), .byte_overflow_flag(c),
    .nibble_overflow_flag(dc), .null_result_flag(z));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Issues one operation and counts clocks until done; capped so a hang shows as a count.
  task automatic exec(input logic [3:0] o, input logic [7:0] k, input logic [6:0] a,
      input logic [2:0] p, input logic t);
    {issue, op, lit, adr, pos, tgt} = {1'b1, o, k, a, p, t};
    @(posedge sys_clk);
    @(negedge sys_clk);
    issue = 1'b0;
    for (lat = 0; done !== 1'b1 && lat < 20; lat++) @(negedge sys_clk);
  endtask : exec
  task automatic stop_test();
    if (err_total == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  // Carries out of both nibbles, then an AND that must keep them.
  task automatic t_literal();
    exec(4'h1, 8'h8F, 7'h00, 3'h0, 1'b0);
    `CHK("add", 11'h478, st)
    exec(4'h1, 8'hF1, 7'h00, 3'h0, 1'b0);
    `CHK("carry", 11'h406, st)
    `CHK("cycles", 4, lat)
    exec(4'h2, 8'h7F, 7'h00, 3'h0, 1'b0);
    `CHK("and", 11'h007, st)
    exec(4'h1, 8'h01, 7'h00, 3'h0, 1'b0);
    `CHK("small add", 11'h008, st)
  endtask : t_literal
  // Top register address; read back by zeroing then adding into the accumulator.
  task automatic t_register();
    exec(4'h8, 8'h00, 7'h7F, 3'h0, 1'b0);
    `CHK("clear", 11'h009, st)
    exec(4'h6, 8'h00, 7'h7F, 3'h7, 1'b0);
    exec(4'h6, 8'h00, 7'h7F, 3'h0, 1'b0);
    exec(4'h5, 8'h00, 7'h7F, 3'h0, 1'b0);
    `CHK("bits", 11'h009, st)
    exec(4'h2, 8'h00, 7'h00, 3'h0, 1'b0);
    `CHK("and zero", 11'h001, st)
    exec(4'h3, 8'h00, 7'h7F, 3'h0, 1'b0);
    `CHK("read", 11'h400, st)
    exec(4'h3, 8'h00, 7'h7F, 3'h0, 1'b1);
    `CHK("to reg", 11'h405, st)
    exec(4'h4, 8'h00, 7'h7F, 3'h0, 1'b0);
    `CHK("and reg", 11'h005, st)
  endtask : t_register
  task automatic t_skip();
    exec(4'h8, 8'h00, 7'h10, 3'h0, 1'b0);
    exec(4'h6, 8'h00, 7'h10, 3'h3, 1'b0);
    exec(4'h7, 8'h00, 7'h10, 3'h3, 1'b0);
    `CHK("skip cycles", 8, lat)
    `CHK("skip flag", 1'b1, skip)
    `CHK("skip flags", 11'h005, st)
    exec(4'h7, 8'h00, 7'h10, 3'h2, 1'b0);
    `CHK("no skip", 4, lat)
    `CHK("skip clear", 1'b0, skip)
    exec(4'h0, 8'hFF, 7'h10, 3'h0, 1'b1);
    `CHK("nop cycles", 4, lat)
    exec(4'hF, 8'hFF, 7'h10, 3'h0, 1'b1);
    `CHK("undefined", 11'h005, st)
  endtask : t_skip
  initial begin
    {nrst, issue, tgt, op, lit, adr, pos} = '0;
    repeat (4) @(negedge sys_clk);
    nrst = 1'b1;
    t_literal();
    t_register();
    t_skip();
    stop_test();
  end
  // Eighteen operations of at most nine clocks fit well inside this span.
  initial begin
    #50000;
    err_total++;
    stop_test();
  end
endmodule : test_byte_bit_alu_ops
